//--- src/pmrr_pkg.sv
// Constants, register map and types of the power monitor result register bank
package pmrr_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0]  IDX_BUS   = 6'h02;
	localparam logic [5:0]  IDX_PWR   = 6'h03;
	localparam logic [5:0]  IDX_CUR   = 6'h04;
	localparam logic [5:0]  IDX_CAL   = 6'h05;
	localparam logic [5:0]  IDX_CTRL  = 6'h08;
	localparam logic [5:0]  IDX_IST   = 6'h09;
	localparam logic [5:0]  IDX_IEN   = 6'h0A;
	localparam logic [5:0]  IDX_ICLR  = 6'h0B;
	localparam int          ADDR_LSB  = 2;
	localparam int          ADDR_MSB  = 7;
	// Reset values
	localparam logic [15:0] RST_RES   = 16'h0000;
	localparam logic [12:0] RST_BUS   = 13'h0000;
	localparam logic [2:0]  RST_MODE  = 3'h7;
	localparam logic [1:0]  RST_IRQ   = 2'h0;
	// Control register layout
	localparam int          CTRL_MODE_LSB = 0;
	localparam int          CTRL_MODE_MSB = 2;
	localparam int          CTRL_RANGE    = 3;
	localparam logic [2:0]  MODE_PDOWN    = 3'h0;
	localparam logic [2:0]  MODE_DISABLE  = 3'h4;
	// Bus voltage register layout
	localparam int          BUS_VAL_LSB = 3;
	localparam int          BUS_RDY_BIT = 1;
	localparam int          BUS_OFLOW_BIT = 0;
	localparam int          BUS_TOP     = 12;
	// Interrupt bit positions
	localparam int          IRQ_READY = 0;
	localparam int          IRQ_OFLOW = 1;
	// Arithmetic
	localparam int          CUR_SHIFT = 12;
	localparam logic [28:0] PWR_DIV   = 29'h0001388;
	typedef enum logic [1:0] {
		PMRR_IDLE,
		PMRR_CUR,
		PMRR_PWR,
		PMRR_UPD
	} pmrr_state_t;
endpackage : pmrr_pkg

//--- src/pmrr_top.sv
// Result, calibration and interrupt registers of the power monitor, APB slave
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module pmrr_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        meas_valid,
	input  wire logic [15:0] meas_shunt,
	input  wire logic [12:0] meas_bus,
	output logic             irq
);
	import pmrr_pkg::*;

	pmrr_state_t       state_reg;
	logic        [12:0] bus_val_reg;
	logic        [15:0] pwr_reg;
	logic        [15:0] cur_reg;
	logic        [15:0] cal_reg;
	logic               ready_reg;
	logic               oflow_reg;
	logic        [2:0]  mode_reg;
	logic               range32_reg;
	logic        [1:0]  ist_reg;
	logic        [1:0]  ien_reg;
	logic        [15:0] shunt_hold;
	logic        [12:0] bus_hold;
	logic        [15:0] cur_tmp;
	logic        [15:0] pwr_tmp;
	logic               oflow_tmp;
	logic        [31:0] prdata_reg;
	logic               pready_reg;
	logic               pslverr_reg;
	logic               irq_reg;

	logic        [5:0]  idx;
	logic               xfer_done;
	logic               wr_done;
	logic               rd_done;
	logic               mapped;
	logic               mode_active;
	logic               mode_wr;
	logic               pwr_rd;
	logic               upd_now;
	logic signed [32:0] cur_prod;
	logic signed [32:0] cur_scaled;
	logic        [15:0] cur_mag;
	logic        [28:0] pwr_prod;
	logic        [28:0] pwr_quot;
	logic        [31:0] rd_word;

	function automatic logic fits_s16(input logic signed [32:0] v);
		fits_s16 = (v[32:15] == 18'h00000) || (v[32:15] == 18'h3FFFF);
	endfunction : fits_s16

	function automatic logic active_mode(input logic [2:0] m);
		active_mode = (m != MODE_PDOWN) && (m != MODE_DISABLE);
	endfunction : active_mode

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq     = irq_reg;

	assign idx         = paddr[ADDR_MSB:ADDR_LSB];
	assign xfer_done   = psel && penable && pready_reg;
	assign wr_done     = xfer_done && pwrite && mapped;
	assign rd_done     = xfer_done && !pwrite && mapped;
	assign mode_active = active_mode(mode_reg);
	assign mode_wr     = wr_done && (idx == IDX_CTRL)
		&& active_mode(pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
	assign pwr_rd      = rd_done && (idx == IDX_PWR);
	assign upd_now     = (state_reg == PMRR_UPD);

	always_comb
	begin
		if (idx == IDX_BUS || idx == IDX_PWR || idx == IDX_CUR
			|| idx == IDX_CAL || idx == IDX_CTRL || idx == IDX_IST
			|| idx == IDX_IEN || idx == IDX_ICLR)
			mapped = (paddr[31:ADDR_MSB+1] == '0)
				&& (paddr[ADDR_LSB-1:0] == 2'h0);
		else
			mapped = 1'b0;
	end

	// Bus word composed from live fields: value, unused bit, ready, overflow
	always_comb
	begin
		rd_word = 32'h00000000;
		if (idx == IDX_BUS)
			rd_word[15:0] = {bus_val_reg, 1'b0, ready_reg, oflow_reg};
		else if (idx == IDX_PWR)
			rd_word[15:0] = pwr_reg;
		else if (idx == IDX_CUR)
			rd_word[15:0] = cur_reg;
		else if (idx == IDX_CAL)
			rd_word[15:0] = cal_reg;
		else if (idx == IDX_CTRL)
			rd_word[3:0] = {range32_reg, mode_reg};
		else if (idx == IDX_IST)
			rd_word[1:0] = ist_reg;
		else if (idx == IDX_IEN)
			rd_word[1:0] = ien_reg;
		else
			rd_word = 32'h00000000;
	end

	// Access phase takes two cycles so read data is already registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end
		else
		begin
			pready_reg  <= psel && penable && !pready_reg;
			pslverr_reg <= psel && penable && !pready_reg && !mapped;
			if (psel && penable && !pready_reg && !pwrite && mapped)
				prdata_reg <= rd_word;
			else
				prdata_reg <= 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_reg    <= RST_MODE;
			range32_reg <= 1'b0;
			ien_reg     <= RST_IRQ;
		end
		else if (wr_done && idx == IDX_CTRL)
		begin
			mode_reg    <= pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB];
			range32_reg <= pwdata[CTRL_RANGE];
		end
		else if (wr_done && idx == IDX_IEN)
			ien_reg <= pwdata[1:0];
	end

	// D0 is never stored, so it cannot be written to one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cal_reg <= RST_RES;
		else if (wr_done && idx == IDX_CAL)
			cal_reg <= {pwdata[15:1], 1'b0};
	end

	// Measurement sequencer; new samples are ignored until the update is done
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= PMRR_IDLE;
		else
			case (state_reg)
				PMRR_IDLE:
					if (meas_valid && mode_active)
						state_reg <= PMRR_CUR;
				PMRR_CUR:
					state_reg <= PMRR_PWR;
				PMRR_PWR:
					state_reg <= PMRR_UPD;
				default:
					state_reg <= PMRR_IDLE;
			endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shunt_hold <= RST_RES;
			bus_hold   <= RST_BUS;
		end
		else if (state_reg == PMRR_IDLE && meas_valid && mode_active)
		begin
			shunt_hold <= meas_shunt;
			// 16V range: 4mV steps, top value bit forced to zero
			bus_hold   <= range32_reg ? meas_bus
				: {1'b0, meas_bus[BUS_TOP-1:0]};
		end
	end

	// Calibration D0 is stored as zero, so the full word is D15..D1 alone
	assign cur_prod   = $signed(shunt_hold)
		* $signed({1'b0, cal_reg});
	assign cur_scaled = cur_prod >>> CUR_SHIFT;
	assign cur_mag    = cur_tmp[15] ? 16'(-cur_tmp) : cur_tmp;
	// Both operands widened first so the product keeps all 29 bits
	assign pwr_prod   = {13'h0000, cur_mag} * {16'h0000, bus_hold};
	assign pwr_quot   = pwr_prod / PWR_DIV;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cur_tmp <= RST_RES;
			pwr_tmp <= RST_RES;
			oflow_tmp <= 1'b0;
		end
		else if (state_reg == PMRR_CUR)
		begin
			cur_tmp <= cur_scaled[15:0];
			oflow_tmp <= !fits_s16(cur_scaled);
		end
		else if (state_reg == PMRR_PWR)
		begin
			pwr_tmp <= pwr_quot[15:0];
			oflow_tmp <= oflow_tmp || (pwr_quot[28:16] != 13'h0000);
		end
	end

	// Results change only here, all in one edge; reads never see a mix
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_val_reg <= RST_BUS;
			cur_reg     <= RST_RES;
			pwr_reg     <= RST_RES;
			oflow_reg   <= 1'b0;
		end
		else if (upd_now)
		begin
			bus_val_reg <= bus_hold;
			cur_reg     <= cur_tmp;
			pwr_reg     <= pwr_tmp;
			oflow_reg   <= oflow_tmp;
		end
	end

	// Set wins over both clear causes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ready_reg <= 1'b0;
		else if (upd_now)
			ready_reg <= 1'b1;
		else if (mode_wr || pwr_rd)
			ready_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ist_reg <= RST_IRQ;
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (upd_now && (i == IRQ_READY || oflow_tmp))
					ist_reg[i] <= 1'b1;
				else if (wr_done && idx == IDX_ICLR && pwdata[i])
					ist_reg[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(ist_reg & ien_reg);
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_BUS_TOP_16V: assert property (
		(upd_now && !range32_reg && $past(!range32_reg, 3))
		|=> (bus_val_reg[BUS_TOP] == 1'b0))
		else $error("bus top bit set in 16V range");
	AST_READY_AFTER_UPD: assert property (
		upd_now |=> ready_reg && (cur_reg == $past(cur_tmp))
		&& (pwr_reg == $past(pwr_tmp)))
		else $error("ready not set after update");
	AST_READY_ONLY_UPD: assert property (
		$rose(ready_reg) |-> $past(upd_now))
		else $error("ready rose without update");
	AST_SEQ_LEN: assert property (
		(state_reg == PMRR_IDLE && meas_valid && mode_active)
		|=> (state_reg == PMRR_CUR) ##1 (state_reg == PMRR_PWR)
		##1 upd_now ##1 ready_reg)
		else $error("measurement sequence broken");
	AST_PWR_READ_CLR: assert property (
		(pwr_rd && !upd_now) |=> !ready_reg)
		else $error("power read did not clear ready");
	AST_MODE_CLR: assert property (
		(mode_wr && !upd_now) |=> !ready_reg)
		else $error("mode write did not clear ready");
	AST_MODE_KEEP: assert property (
		(ready_reg && wr_done && idx == IDX_CTRL && !mode_wr && !pwr_rd)
		|=> ready_reg)
		else $error("inactive mode write cleared ready");
	AST_CAL_D0: assert property (
		cal_reg[0] == 1'b0)
		else $error("calibration bit zero set");
	AST_RESULTS_HOLD: assert property (
		!upd_now |=> $stable(cur_reg) && $stable(pwr_reg)
		&& $stable(bus_val_reg))
		else $error("results changed outside update");
	AST_OFLOW_TRACK: assert property (
		upd_now |=> (oflow_reg == $past(oflow_tmp)) && ist_reg[IRQ_READY])
		else $error("overflow flag not updated");
	AST_PREADY_PULSE: assert property (
		pready_reg |=> !pready_reg)
		else $error("pready held more than one cycle");
	AST_IRQ_LEVEL: assert property (
		(|(ist_reg & ien_reg)) |=> irq_reg)
		else $error("interrupt not raised");

	COV_MEAS: cover property (upd_now ##1 ready_reg);
	COV_OFLOW: cover property (upd_now && oflow_tmp);
	COV_PWR_READ: cover property (ready_reg && pwr_rd ##1 !ready_reg);
	COV_SLVERR: cover property (pready_reg && pslverr_reg);
endmodule : pmrr_top

//--- verif/pmrr_host.sv
// Host model: APB master issuing register reads and writes
`timescale 1ns/1ps
module pmrr_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [31:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	int hangs;
	initial
	begin
		hangs = 0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
	end
	// Request held until pready is sampled; released lines show inverse
	task automatic xfer(input logic wr, input logic [5:0] idx,
		input logic [31:0] d, output logic [31:0] q, output logic err);
		int n;
		q = 32'hX;
		err = 1'bX;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {24'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
			begin
				q = prdata;
				err = pslverr;
				break;
			end
		end
		if (n == 50)
			hangs++;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~{24'h0, idx, 2'h0};
		pwdata <= ~d;
	endtask : xfer
endmodule : pmrr_host

//--- verif/pmrr_tb.sv
// Self-checking testbench of the result register bank
`timescale 1ns/1ps
module tb_top;
	import pmrr_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        meas_valid;
	logic [15:0] meas_shunt;
	logic [12:0] meas_bus;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] q;
	logic        e;
	int          fails;
	int          comparisons;

	pmrr_top pmrr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .meas_valid(meas_valid),
		.meas_shunt(meas_shunt), .meas_bus(meas_bus), .irq(irq));
	pmrr_host pmrr_host_inst (.pclk(pclk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic end_of_test();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] y);
		comparisons++;
		if (x !== y)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, x, y);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [5:0] i,
		input logic [31:0] d);
		pmrr_host_inst.xfer(wr, i, d, q, e);
		if (pmrr_host_inst.hangs != 0)
		begin
			fails++;
			end_of_test();
		end
	endtask : bus

	task automatic rd(input logic [5:0] i, input logic [31:0] x);
		bus(1'b0, i, 32'h0);
		chk("read data", x, q);
	endtask : rd

	task automatic meas(input logic [15:0] s, input logic [12:0] b);
		@(posedge pclk);
		meas_valid <= 1'b1;
		meas_shunt <= s;
		meas_bus <= b;
		@(posedge pclk);
		meas_valid <= 1'b0;
		// Update lands three edges after the take, irq one later
		repeat (5) @(posedge pclk);
	endtask : meas

	task automatic t_reset();
		rd(IDX_BUS, 32'h0);
		rd(IDX_PWR, 32'h0);
		rd(IDX_CUR, 32'h0);
		rd(IDX_CAL, 32'h0);
	endtask : t_reset

	task automatic t_cal();
		bus(1'b1, IDX_CAL, 32'hFFFF);
		rd(IDX_CAL, 32'hFFFE);
		bus(1'b1, IDX_CAL, 32'h1001);
		rd(IDX_CAL, 32'h1000);
	endtask : t_cal

	// Odd scale value must act as 0x1000, top bus bit forced low
	task automatic t_meas();
		bus(1'b1, IDX_IEN, 32'h1);
		meas(16'h4000, 13'h1FFF);
		chk("irq", 32'h1, {31'h0, irq});
		rd(IDX_BUS, 32'h7FFA);
		rd(IDX_CUR, 32'h4000);
		rd(IDX_PWR, 32'h346A);
		rd(IDX_BUS, 32'h7FF8);
		rd(IDX_IST, 32'h1);
		bus(1'b1, IDX_ICLR, 32'h1);
		@(posedge pclk);
		@(posedge pclk);
		chk("irq", 32'h0, {31'h0, irq});
	endtask : t_meas

	task automatic t_neg();
		bus(1'b1, IDX_IEN, 32'h0);
		meas(16'hFFFB, 13'h03E8);
		chk("irq", 32'h0, {31'h0, irq});
		rd(IDX_IST, 32'h1);
		rd(IDX_CUR, 32'hFFFB);
		bus(1'b1, IDX_CTRL, 32'h4);
		rd(IDX_BUS, 32'h1F42);
		bus(1'b1, IDX_CTRL, 32'h7);
		rd(IDX_BUS, 32'h1F40);
		rd(IDX_PWR, 32'h1);
	endtask : t_neg

	task automatic t_oflow();
		bus(1'b1, IDX_CAL, 32'h7FFE);
		meas(16'h7FFF, 13'h03E8);
		rd(IDX_BUS, 32'h1F43);
		rd(IDX_IST, 32'h3);
		bus(1'b1, IDX_BUS, 32'hFFFF);
		rd(IDX_BUS, 32'h1F43);
	endtask : t_oflow

	// Power-down keeps ready and drops samples; 32V range keeps top bit
	task automatic t_mode();
		bus(1'b1, IDX_CTRL, 32'h8);
		rd(IDX_CTRL, 32'h8);
		meas(16'h0000, 13'h1FFF);
		rd(IDX_BUS, 32'h1F43);
		bus(1'b1, IDX_CTRL, 32'hF);
		rd(IDX_BUS, 32'h1F41);
		meas(16'h0000, 13'h1FFF);
		rd(IDX_BUS, 32'hFFFA);
		rd(IDX_CUR, 32'h0);
	endtask : t_mode

	task automatic t_err();
		bus(1'b0, 6'h0F, 32'h0);
		chk("pslverr", 32'h1, {31'h0, e});
		chk("read data", 32'h0, q);
	endtask : t_err

	initial
	begin
		fails = 0;
		comparisons = 0;
		presetn = 1'b0;
		meas_valid = 1'b0;
		meas_shunt = 16'h0;
		meas_bus = 13'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_cal();
		t_meas();
		t_neg();
		t_oflow();
		t_mode();
		t_err();
		end_of_test();
	end
endmodule : tb_top
